// File: core/adcsm_pkg.sv
package adcsm_pkg;
	localparam int RES_W = 10;
	localparam int NUM_RES = 12;
	localparam int MON_N = 2;
	localparam int CH_W = 4;
	localparam int REG_W = 32;
	localparam int OFF_W = 8;
	// Byte offsets
	localparam logic [7:0] OFF_MODE0 = 8'h00;
	localparam logic [7:0] OFF_MODE1 = 8'h04;
	localparam logic [7:0] OFF_MODE2 = 8'h08;
	localparam logic [7:0] OFF_MON_CTL [MON_N] = '{8'h0C, 8'h10};
	localparam logic [7:0] OFF_MON_THR [MON_N] = '{8'h14, 8'h18};
	localparam logic [7:0] OFF_PRI_RES = 8'h1C;
	localparam logic [7:0] OFF_RES0 = 8'h20;
	localparam logic [7:0] RES_SPAN = 8'h30;
	// mode_ctrl_zero
	localparam int M0_START = 0;
	localparam int M0_SCAN = 1;
	localparam int M0_REPEAT = 2;
	localparam int M0_ITM = 3;
	localparam int M0_DONE = 6;
	localparam int M0_BUSY = 7;
	// mode_ctrl_one
	localparam int M1_CH = 0;
	localparam int M1_SCN = 4;
	localparam int M1_REF = 6;
	localparam int M1_PWR = 7;
	// mode_ctrl_two
	localparam int M2_PCH = 0;
	localparam int M2_PSTART = 4;
	localparam int M2_PDONE = 5;
	localparam int M2_PBUSY = 6;
	// mode_ctrl_three / mode_ctrl_five
	localparam int MC_EN = 0;
	localparam int MC_SEL = 1;
	localparam int MC_DIR = 5;
	// Result and threshold layout
	localparam int RES_LSB = 6;
	localparam int RES_OVR = 1;
	localparam int RES_STO = 0;
	// Last index of a scan or of a repeat interrupt interval
	localparam logic [1:0] SEL_A = 2'h0;
	localparam logic [1:0] SEL_B = 2'h1;
	localparam logic [1:0] SEL_C = 2'h2;
	localparam logic [3:0] LAST_1 = 4'h0;
	localparam logic [3:0] LAST_4 = 4'h3;
	localparam logic [3:0] LAST_8 = 4'h7;
	localparam logic [3:0] LAST_12 = 4'hB;
	typedef enum logic [1:0] {ADCSM_IDLE, ADCSM_NORM, ADCSM_PRIO} adcsm_seq_t;
endpackage

// File: core/adcsm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adcsm_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Settings
	input wire logic enable,
	input wire logic [3:0] sourceSel,
	input wire logic direction,
	input wire logic [adcsm_pkg::RES_W-1:0] threshold,
	// Result store strobe
	input wire logic storeValid,
	input wire logic storePriority,
	input wire logic [adcsm_pkg::CH_W-1:0] storeIndex,
	input wire logic [adcsm_pkg::RES_W-1:0] storeData,
	// Request
	output logic monitorIrq
);
	import adcsm_pkg::*;

	typedef struct packed {
		logic irq;
	} adcsm_mon_state_t;

	adcsm_mon_state_t q;
	adcsm_mon_state_t next_q;
	logic srcMatch;
	logic crossed;

	// Upper selector bit picks the priority result
	assign srcMatch = sourceSel[3] ? storePriority
		: (!storePriority && storeIndex == {1'b0, sourceSel[2:0]});
	assign crossed = direction ? (storeData > threshold)
		: (storeData < threshold);

	always_comb begin
		next_q = q;
		next_q.irq = enable && storeValid && srcMatch && crossed;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign monitorIrq = q.irq;
endmodule
`default_nettype wire

// File: core/adcsm_core.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adcsm_core #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [adcsm_pkg::REG_W-1:0] pwdata,
	output logic [adcsm_pkg::REG_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog core
	output logic convStart,
	output logic [adcsm_pkg::CH_W-1:0] convChannel,
	input wire logic convDone,
	input wire logic [adcsm_pkg::RES_W-1:0] convData,
	output logic referenceEnable,
	output logic analogPowerEnable,
	// Interrupt requests
	output logic normalDoneIrq,
	output logic priorityDoneIrq,
	output logic [adcsm_pkg::MON_N-1:0] monitorIrq
);
	import adcsm_pkg::*;

	if (ADDR_W < OFF_W) begin
		$error("ADDR_W must be at least 8");
	end

	typedef struct packed {
		adcsm_seq_t seq;
		logic normBusy;
		logic normDone;
		logic priBusy;
		logic priDone;
		logic scanMode;
		logic repeatMode;
		logic [1:0] itmSel;
		logic [CH_W-1:0] chSel;
		logic [1:0] scnSel;
		logic refEn;
		logic pwrEn;
		logic [CH_W-1:0] priCh;
		logic [MON_N-1:0] monEn;
		logic [MON_N-1:0] monDir;
		logic [MON_N-1:0][3:0] monSel;
		logic [MON_N-1:0][RES_W-1:0] monThr;
		logic [NUM_RES-1:0][RES_W-1:0] resData;
		logic [NUM_RES-1:0] resSto;
		logic [NUM_RES-1:0] resOvr;
		logic [RES_W-1:0] priData;
		logic priSto;
		logic priOvr;
		logic [CH_W-1:0] idx;
		logic [CH_W-1:0] rptCnt;
		logic convStart;
		logic [CH_W-1:0] convCh;
		logic normIrq;
		logic priIrq;
		logic apbReady;
		logic apbErr;
		logic [REG_W-1:0] apbRdata;
	} adcsm_state_t;

	adcsm_state_t q;
	adcsm_state_t next_q;

	logic [7:0] regOff;
	logic upperZero;
	logic resHit;
	logic [CH_W-1:0] resSel;
	logic mapped;
	logic hitMode0;
	logic hitMode1;
	logic hitMode2;
	logic hitPri;
	logic [MON_N-1:0] hitMonCtl;
	logic [MON_N-1:0] hitMonThr;
	logic [REG_W-1:0] rdMux;
	logic capture;
	logic finish;
	logic normStartReq;
	logic priStartReq;
	logic [CH_W-1:0] scanLast;
	logic [CH_W-1:0] itmLast;
	logic stValid;
	logic stPri;
	logic [CH_W-1:0] stIdx;
	logic endCycle;

	// Scan group starts at the input select and wraps past the last input
	function automatic logic [CH_W-1:0] wrapCh(
		input logic [CH_W-1:0] base,
		input logic [CH_W-1:0] off
	);
		logic [CH_W:0] s;
		s = {1'b0, base} + {1'b0, off};
		if (s >= (CH_W+1)'(NUM_RES)) begin
			s = s - (CH_W+1)'(NUM_RES);
		end
		return s[CH_W-1:0];
	endfunction

	assign regOff = {paddr[7:2], 2'b00};
	assign upperZero = (paddr >> OFF_W) == '0;
	assign resHit = regOff >= OFF_RES0 && regOff < OFF_RES0 + RES_SPAN;
	assign resSel = CH_W'((regOff - OFF_RES0) >> 2);
	// Read effects on the first access cycle, write effects on the last
	assign capture = psel && penable && !q.apbReady;
	assign finish = psel && penable && q.apbReady;
	assign normStartReq = finish && pwrite && hitMode0
		&& pwdata[M0_START];
	assign priStartReq = finish && pwrite && hitMode2
		&& pwdata[M2_PSTART];

	always_comb begin
		case (q.scnSel)
			SEL_A: scanLast = LAST_4;
			SEL_B: scanLast = LAST_8;
			default: scanLast = LAST_12;
		endcase
		case (q.itmSel)
			SEL_A: itmLast = LAST_1;
			SEL_B: itmLast = LAST_4;
			SEL_C: itmLast = LAST_8;
			default: itmLast = LAST_12;
		endcase
	end

	// Address decode and read data
	always_comb begin
		rdMux = '0;
		hitMode0 = 1'b0;
		hitMode1 = 1'b0;
		hitMode2 = 1'b0;
		hitPri = 1'b0;
		hitMonCtl = '0;
		hitMonThr = '0;
		if (upperZero) begin
			for (int m = 0; m < MON_N; m++) begin
				if (regOff == OFF_MON_CTL[m]) begin
					hitMonCtl[m] = 1'b1;
					rdMux[MC_EN] = q.monEn[m];
					rdMux[MC_SEL +: 4] = q.monSel[m];
					rdMux[MC_DIR] = q.monDir[m];
				end
				if (regOff == OFF_MON_THR[m]) begin
					hitMonThr[m] = 1'b1;
					rdMux[RES_LSB +: RES_W] = q.monThr[m];
				end
			end
			if (regOff == OFF_MODE0) begin
				hitMode0 = 1'b1;
				rdMux[M0_SCAN] = q.scanMode;
				rdMux[M0_REPEAT] = q.repeatMode;
				rdMux[M0_ITM +: 2] = q.itmSel;
				rdMux[M0_DONE] = q.normDone;
				rdMux[M0_BUSY] = q.normBusy;
			end else if (regOff == OFF_MODE1) begin
				hitMode1 = 1'b1;
				rdMux[M1_CH +: CH_W] = q.chSel;
				rdMux[M1_SCN +: 2] = q.scnSel;
				rdMux[M1_REF] = q.refEn;
				rdMux[M1_PWR] = q.pwrEn;
			end else if (regOff == OFF_MODE2) begin
				hitMode2 = 1'b1;
				rdMux[M2_PCH +: CH_W] = q.priCh;
				rdMux[M2_PDONE] = q.priDone;
				rdMux[M2_PBUSY] = q.priBusy;
			end else if (regOff == OFF_PRI_RES) begin
				hitPri = 1'b1;
				rdMux[RES_LSB +: RES_W] = q.priData;
				rdMux[RES_OVR] = q.priOvr;
				rdMux[RES_STO] = q.priSto;
			end else if (resHit) begin
				rdMux[RES_LSB +: RES_W] = q.resData[resSel];
				rdMux[RES_OVR] = q.resOvr[resSel];
				rdMux[RES_STO] = q.resSto[resSel];
			end
		end
		mapped = hitMode0 || hitMode1 || hitMode2 || hitPri
			|| (upperZero && resHit) || (|hitMonCtl) || (|hitMonThr);
	end

	always_comb begin
		next_q = q;
		next_q.convStart = 1'b0;
		next_q.normIrq = 1'b0;
		next_q.priIrq = 1'b0;
		stValid = 1'b0;
		stPri = 1'b0;
		stIdx = '0;
		endCycle = 1'b0;

		// Bus: clears first, so a store in the same cycle wins
		if (capture) begin
			next_q.apbReady = 1'b1;
			next_q.apbRdata = rdMux;
			next_q.apbErr = !mapped;
			if (!pwrite) begin
				if (hitMode0) begin
					next_q.normDone = 1'b0;
				end
				if (hitMode2) begin
					next_q.priDone = 1'b0;
				end
				if (hitPri) begin
					next_q.priSto = 1'b0;
					next_q.priOvr = 1'b0;
				end
				if (upperZero && resHit) begin
					next_q.resSto[resSel] = 1'b0;
					next_q.resOvr[resSel] = 1'b0;
				end
			end
		end else if (finish) begin
			next_q.apbReady = 1'b0;
			next_q.apbErr = 1'b0;
			if (pwrite) begin
				if (hitMode0) begin
					next_q.scanMode = pwdata[M0_SCAN];
					next_q.repeatMode = pwdata[M0_REPEAT];
					next_q.itmSel = pwdata[M0_ITM +: 2];
				end
				if (hitMode1) begin
					next_q.chSel = pwdata[M1_CH +: CH_W];
					next_q.scnSel = pwdata[M1_SCN +: 2];
					next_q.refEn = pwdata[M1_REF];
					next_q.pwrEn = pwdata[M1_PWR];
				end
				if (hitMode2) begin
					next_q.priCh = pwdata[M2_PCH +: CH_W];
				end
				for (int m = 0; m < MON_N; m++) begin
					if (hitMonCtl[m]) begin
						next_q.monEn[m] = pwdata[MC_EN];
						next_q.monSel[m] = pwdata[MC_SEL +: 4];
						next_q.monDir[m] = pwdata[MC_DIR];
					end
					if (hitMonThr[m]) begin
						next_q.monThr[m] = pwdata[RES_LSB +: RES_W];
					end
				end
			end
		end

		// Conversion completion
		case (q.seq)
			ADCSM_IDLE: begin
				next_q.seq = ADCSM_IDLE;
			end
			ADCSM_NORM: begin
				if (convDone) begin
					stValid = 1'b1;
					if (q.scanMode) begin
						stIdx = q.idx;
						endCycle = q.idx >= scanLast;
						next_q.idx = endCycle ? '0 : q.idx + 4'h1;
					end else if (q.repeatMode) begin
						stIdx = q.rptCnt;
						endCycle = q.rptCnt >= itmLast;
						next_q.rptCnt = endCycle ? '0 : q.rptCnt + 4'h1;
					end else begin
						stIdx = q.chSel;
						endCycle = 1'b1;
					end
					if (endCycle) begin
						next_q.normDone = 1'b1;
						next_q.normIrq = 1'b1;
					end
					// Clearing repeat stops after the running conversion, or at the end of the running scan in scan mode
					if (endCycle && !q.repeatMode) begin
						next_q.normBusy = 1'b0;
						next_q.seq = ADCSM_IDLE;
					end else begin
						next_q.convStart = 1'b1;
						next_q.convCh = q.scanMode
							? wrapCh(q.chSel, next_q.idx) : q.chSel;
					end
				end
			end
			ADCSM_PRIO: begin
				if (convDone) begin
					stValid = 1'b1;
					stPri = 1'b1;
					next_q.priBusy = 1'b0;
					next_q.priDone = 1'b1;
					next_q.priIrq = 1'b1;
					if (q.normBusy) begin
						next_q.seq = ADCSM_NORM;
						next_q.convStart = 1'b1;
						next_q.convCh = q.scanMode
							? wrapCh(q.chSel, q.idx) : q.chSel;
					end else begin
						next_q.seq = ADCSM_IDLE;
					end
				end
			end
			default: begin
				next_q.seq = ADCSM_IDLE;
			end
		endcase

		// Result store; overrun only if the old value went unread
		if (stValid) begin
			if (stPri) begin
				next_q.priOvr = next_q.priOvr | next_q.priSto;
				next_q.priSto = 1'b1;
				next_q.priData = convData;
			end else if (stIdx < CH_W'(NUM_RES)) begin
				next_q.resOvr[stIdx] = next_q.resOvr[stIdx]
					| next_q.resSto[stIdx];
				next_q.resSto[stIdx] = 1'b1;
				next_q.resData[stIdx] = convData;
			end
		end

		// Starts; a priority start abandons a running normal conversion, other starts on a busy core are ignored
		if (normStartReq && q.seq == ADCSM_IDLE && !q.priBusy) begin
			next_q.normBusy = 1'b1;
			next_q.idx = '0;
			next_q.rptCnt = '0;
			next_q.seq = ADCSM_NORM;
			next_q.convStart = 1'b1;
			next_q.convCh = next_q.chSel;
		end
		if (priStartReq && !q.priBusy) begin
			next_q.priBusy = 1'b1;
			next_q.seq = ADCSM_PRIO;
			next_q.convStart = 1'b1;
			next_q.convCh = next_q.priCh;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	for (genvar g = 0; g < MON_N; g++) begin : g_mon
		adcsm_monitor u_mon (
			.clk_sys(clk_sys),
			.reset(reset),
			.enable(q.monEn[g]),
			.sourceSel(q.monSel[g]),
			.direction(q.monDir[g]),
			.threshold(q.monThr[g]),
			.storeValid(stValid),
			.storePriority(stPri),
			.storeIndex(stIdx),
			.storeData(convData),
			.monitorIrq(monitorIrq[g])
		);
	end

	assign prdata = q.apbRdata;
	assign pready = q.apbReady;
	assign pslverr = q.apbErr;
	assign convStart = q.convStart;
	assign convChannel = q.convCh;
	assign referenceEnable = q.refEn;
	assign analogPowerEnable = q.pwrEn;
	assign normalDoneIrq = q.normIrq;
	assign priorityDoneIrq = q.priIrq;
endmodule
`default_nettype wire

// File: tb/adcsm_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module adcsm_core_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adcsm_pkg::REG_W-1:0] prdata,
	input wire logic pready,
	// Core and requests
	input wire logic convStart,
	input wire logic convDone,
	input wire logic normalDoneIrq,
	input wire logic priorityDoneIrq,
	input wire logic [adcsm_pkg::MON_N-1:0] monitorIrq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	a_one_wait: assert property (s_wait |=> pready)
		else $error("pready late");
	a_start_cause: assert property (convStart |-> $past(convDone) ||
		$past(psel && penable && pready && pwrite))
		else $error("start without cause");
	a_norm_cause: assert property (normalDoneIrq |-> $past(convDone))
		else $error("normal irq without done");
	a_prio_cause: assert property (priorityDoneIrq |-> $past(convDone))
		else $error("priority irq without done");
	a_mon_cause: assert property (|monitorIrq |-> $past(convDone))
		else $error("monitor irq without store");
	a_norm_pulse: assert property (normalDoneIrq |=> !normalDoneIrq)
		else $error("normal irq too long");
	a_prio_pulse: assert property (priorityDoneIrq |=> !priorityDoneIrq)
		else $error("priority irq too long");
	a_mon_pulse: assert property (|monitorIrq |=>
		(monitorIrq & $past(monitorIrq)) == 2'b00)
		else $error("monitor irq too long");
	a_upper_zero: assert property (pready && !pwrite |->
		prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
endmodule
`default_nettype wire

// File: tb/adcsm_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcsm_analog_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Conversion
	input wire logic convStart,
	input wire logic [7:0] delay,
	input wire logic [9:0] value,
	output logic convDone,
	output logic [9:0] convData
);
	int cnt;
	always_ff @(posedge clk_sys) begin
		convDone <= 1'b0;
		// Data is only valid with the done pulse
		convData <= ~convData;
		if (reset) begin
			cnt <= 0;
			convData <= 10'h155;
		end else if (convStart) begin
			cnt <= int'(delay) + 1;
		end else if (cnt == 1) begin
			convDone <= 1'b1;
			convData <= value;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin n_fail++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module testbench;
	import adcsm_pkg::*;
	localparam logic [3:0] CH_SEQ [6] = '{4'h0, 4'h1, 4'h5, 4'h1, 4'h2, 4'h3};
	// Repeat modes: fixed with interval 4, scan repeat, then fixed with intervals 8, 12 and 1
	localparam logic [31:0] RPT_MODE [5] = '{32'h0000_000D, 32'h0000_0007,
		32'h0000_0015, 32'h0000_001D, 32'h0000_0005};
	localparam int RPT_N [5] = '{4, 4, 8, 12, 1};
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, convStart, convDone, normalDoneIrq, priorityDoneIrq;
	logic referenceEnable, analogPowerEnable;
	logic [3:0] convChannel;
	logic [9:0] convData;
	logic [9:0] value = 10'h000;
	logic [9:0] tv;
	logic [7:0] dly = 8'h02;
	logic [1:0] monitorIrq;
	logic [32:0] expQ[$];
	logic [31:0] mskQ[$];
	logic [3:0] chQ[$];
	int n_fail = 0, checked = 0, nStart = 0, nAtIrq = 0;
	int nNorm = 0, nPrio = 0, nMon0 = 0, nMon1 = 0;
	always #20 clk_sys = ~clk_sys;
	adcsm_core dut_u (.clk_sys(clk_sys), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.convStart(convStart), .convChannel(convChannel), .convDone(convDone),
		.convData(convData), .referenceEnable(referenceEnable),
		.analogPowerEnable(analogPowerEnable), .normalDoneIrq(normalDoneIrq),
		.priorityDoneIrq(priorityDoneIrq), .monitorIrq(monitorIrq));
	adcsm_analog_model core_u (.clk_sys(clk_sys), .reset(reset),
		.convStart(convStart), .delay(dly), .value(value),
		.convDone(convDone), .convData(convData));
	always @(posedge clk_sys) begin
		if (normalDoneIrq) nAtIrq = nStart;
		if (normalDoneIrq) nNorm++;
		if (priorityDoneIrq) nPrio++;
		if (monitorIrq[0]) nMon0++;
		if (monitorIrq[1]) nMon1++;
		if (convStart) begin
			nStart++;
			chQ.push_back(convChannel);
		end
		if (psel && penable && pready && !pwrite) begin
			`CHK("prdata", expQ[0][31:0], prdata & mskQ[0])
			`CHK("pslverr", expQ[0][32], pslverr)
			void'(expQ.pop_front());
			void'(mskQ.pop_front());
		end
	end
	// Whole-word transfers only, never byte lanes
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// Negedge polling keeps the counters settled
	task automatic upto(ref int c, input int t);
		for (int i = 0; i < 4000 && c < t; i++) @(negedge clk_sys);
		`CHK("wait", 1, c >= t)
		@(posedge clk_sys);
	endtask
	task prio;
		apb(1'b1, OFF_MODE2, 32'h0000_0019);
		upto(nPrio, nPrio + 1);
	endtask
	task print_verdict;
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Tests need under 2000 cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'ha513_0fab));
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(OFF_PRI_RES, 33'h0, 32'hFFFF_FFFF);
		rd(OFF_MON_THR[1], 33'h0, 32'hFFFF_FFFF);
		rd(8'hFC, 33'h1_0000_0000, 32'hFFFF_FFFF);
		apb(1'b1, OFF_MODE1, 32'h0000_00C0);
		repeat (75) @(posedge clk_sys);
		`CHK("refEn", 1'b1, referenceEnable)
		`CHK("pwrEn", 1'b1, analogPowerEnable)
		tv = 10'($urandom_range(1, 1021));
		apb(1'b1, OFF_MON_THR[0], {16'h0000, tv, 6'h3F});
		rd(OFF_MON_THR[0], {17'h0, tv, 6'h00}, 32'hFFFF_FFFF);
		apb(1'b1, OFF_MON_THR[1], 32'h0000_FFFF);
		apb(1'b1, OFF_MON_CTL[0], 32'h0000_0031);
		apb(1'b1, OFF_MON_CTL[1], 32'h0000_0001);
		value <= tv + 10'h001;
		prio();
		`CHK("mon0", 1, nMon0)
		rd(OFF_MODE2, 33'h20, 32'h60);
		rd(OFF_MODE2, 33'h0, 32'h20);
		rd(OFF_PRI_RES, {17'h0, value, 6'h01}, 32'hFFFF_FFFF);
		rd(OFF_PRI_RES, {17'h0, value, 6'h00}, 32'hFFFF_FFFF);
		value <= tv;
		prio();
		prio();
		`CHK("mon0", 1, nMon0)
		rd(OFF_PRI_RES, {17'h0, tv, 6'h03}, 32'hFFFF_FFFF);
		rd(OFF_PRI_RES, {17'h0, tv, 6'h00}, 32'hFFFF_FFFF);
		dly <= 8'd40;
		apb(1'b1, OFF_MODE2, 32'h0000_0019);
		rd(OFF_MODE2, 33'h40, 32'h40);
		apb(1'b1, OFF_MODE2, 32'h0000_0019);
		// A restarted conversion would still be running here
		repeat (40) @(posedge clk_sys);
		`CHK("prio", 4, nPrio)
		dly <= 8'(16 + $urandom % 8);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFF_MODE1, 32'h0000_00C0 | 32'((k == 0) ? 0 : (k - 1) << 4));
			nStart = 0;
			apb(1'b1, OFF_MODE0, (k == 0) ? 32'h0000_0001 : 32'h0000_0003);
			rd(OFF_MODE0, 33'h80, 32'h80);
			upto(nNorm, nNorm + 1);
			`CHK("starts", (k == 0) ? 1 : 4 * k, nAtIrq)
			rd(OFF_MODE0, 33'h40, 32'hC0);
		end
		`CHK("mon1", 4, nMon1)
		rd(OFF_RES0, {17'h0, tv, 6'h03}, 32'hFFFF_FFFF);
		apb(1'b1, OFF_MODE1, 32'h0000_00C0);
		nStart = 0;
		chQ.delete();
		apb(1'b1, OFF_MODE0, 32'h0000_0003);
		upto(nStart, 2);
		apb(1'b1, OFF_MODE2, 32'h0000_0015);
		upto(nNorm, nNorm + 1);
		`CHK("starts", 6, nAtIrq)
		for (int i = 0; i < 6; i++) `CHK("chan", CH_SEQ[i], chQ[i])
		for (int k = 0; k < 5; k++) begin
			reset <= 1'b1;
			@(posedge clk_sys);
			reset <= 1'b0;
			@(posedge clk_sys);
			nStart = 0;
			apb(1'b1, OFF_MODE1, 32'h0000_00C0);
			apb(1'b1, OFF_MODE0, RPT_MODE[k]);
			upto(nNorm, nNorm + 1);
			`CHK("starts", RPT_N[k], nAtIrq)
			rd(OFF_MODE0, 33'hC0, 32'hC0);
		end
		print_verdict();
	end
endmodule
bind adcsm_core adcsm_core_sva chk_u (.clk_sys(clk_sys), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .convStart(convStart), .convDone(convDone),
	.normalDoneIrq(normalDoneIrq), .priorityDoneIrq(priorityDoneIrq),
	.monitorIrq(monitorIrq));
`default_nettype wire
